// ---- hw/sfp_map.svh ----
// Purpose: opcodes, phase lengths and timing figures of the serial flash pin front end
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
`define SFP_OP_READ        8'h03
`define SFP_OP_FAST        8'h0B
`define SFP_OP_FAST_DTR    8'h0D
`define SFP_OP_DUAL_OUT    8'h3B
`define SFP_OP_QUAD_OUT    8'h6B
`define SFP_OP_DUAL_IO     8'hBB
`define SFP_OP_QUAD_IO     8'hEB
`define SFP_OP_QIO_DTR     8'hED
`define SFP_OP_PROG        8'h02
`define SFP_OP_QPROG       8'h32
`define SFP_OP_ERASE4K     8'h20
`define SFP_OP_ERASE32K    8'h52
`define SFP_OP_ERASE64K    8'hD8
`define SFP_OP_RDSTAT      8'h05
`define SFP_OP_WRSTAT      8'h01
`define SFP_OP_UID         8'h4B
`define SFP_OP_SECRD       8'h48
`define SFP_OP_SECPROG     8'h42
`define SFP_OP_SECERASE    8'h44
`define SFP_CMD_BITS       6'd8
`define SFP_ADDR_BITS      6'd24
`define SFP_MODE_BITS      6'd8
`define SFP_BYTE_BITS      4'd8
`define SFP_DUMMY_FAST     6'd8
`define SFP_DUMMY_QIO      6'd4
`define SFP_DUMMY_DTR      6'd6
`define SFP_DUMMY_UID      6'd32
`define SFP_CONT_MODE      2'b10
`define SFP_PAGE_BITS      6'd8
`define SFP_WRAP_BASE      6'd3
`define SFP_NO_WRAP        6'd24
`define SFP_SEC_AREA_LO    12
`define SFP_SEC_AREA_HI    13
`define SFP_SMALL_UNIT     5'd12
`define SFP_BLOCK_UNIT     5'd16
`define SFP_SMALL_MAX      5'd15
`define SFP_HWCLR_NS       1000
`define SFP_CLK_NS         20
`define SFP_HWCLR_CYCLES   ((`SFP_HWCLR_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`endif

// ---- hw/sfp_pkg.sv ----
// Purpose: shared types of the serial flash pin front end
// Assumes: nothing beyond the map header
// Notes: types only
package sfp_pkg;
  typedef enum logic [1:0] {LN_1, LN_2, LN_4} sfp_lanes_t;
  typedef enum logic [1:0] {SP_ARRAY, SP_STATUS, SP_UID, SP_SECURE} sfp_space_t;
  typedef enum logic [1:0] {ER_NONE, ER_4K, ER_32K, ER_64K} sfp_erase_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} sfp_dir_t;
  typedef struct packed {
    logic        hasAddr;
    sfp_lanes_t  addrLanes;
    logic        hasMode;
    logic [5:0]  dummy;
    sfp_lanes_t  dataLanes;
    sfp_dir_t    dir;
    logic        dtr;
    sfp_space_t  space;
    sfp_erase_t  erase;
  } sfp_cmd_t;
  typedef struct packed {
    logic [2:0]  blockProtect;
    logic        topBottom;
    logic        smallUnit;
    logic        complement;
    logic [1:0]  statusProtect;
  } sfp_prot_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
    sfp_space_t  space;
  } sfp_xfer_t;
  typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DIN, ST_DOUT, ST_SKIP} sfp_state_t;
endpackage : sfp_pkg

// ---- hw/sfp_protect.sv ----
// Purpose: array and status write protection decode
// Assumes: wpLevel already synchronised
// Notes: purely combinational
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_protect
  import sfp_pkg::*;
(
  // inputs
  input  wire logic [23:0] addr,
  input  wire sfp_prot_t   cfg,
  input  wire logic        wpLevel,
  input  wire logic        quadOn,
  // results
  output logic             arrayProt,
  output logic             statusLock
);
  logic [4:0] unitBits;
  logic       hit;

  always_comb begin
    unitBits = (cfg.smallUnit ? `SFP_SMALL_UNIT : `SFP_BLOCK_UNIT) + {2'b00, cfg.blockProtect} - 5'd1;
    if (cfg.smallUnit && unitBits > `SFP_SMALL_MAX) begin
      unitBits = `SFP_SMALL_MAX;
    end
    if (cfg.blockProtect == 3'b000) begin
      hit = 1'b0;
    end else if (cfg.blockProtect == 3'b111 && !cfg.smallUnit) begin
      hit = 1'b1;
    end else if (cfg.topBottom) begin
      hit = ((addr >> unitBits) == 24'h00_0000);
    end else begin
      hit = ((~addr >> unitBits) == 24'h00_0000);
    end
    arrayProt  = hit ^ cfg.complement; // R08
    // pin lock only counts while the pin is not a quad data line
    statusLock = cfg.statusProtect[1] | (cfg.statusProtect[0] & ~wpLevel & ~quadOn); // R08 R09
  end
endmodule : sfp_protect

// ---- hw/sfp_pin_if.sv ----
// Purpose: device side pin front end of a serial NOR flash (single/dual/quad/quad-command, DTR reads)
// Assumes: host clock well below clk/6; core answers rdReq within two clk cycles
// Notes: array, status store and erase/program engines live in the core behind this block
// Operation
// R01: single line captures on serial clock rise
// R02: output bits launched on serial clock fall
// R03: dual/quad lines 0,1 bidirectional, same edges
// R04: chip select high tristates all outputs
// R05: selected frame takes instructions, returns read data
// R06: ignore commands until chip select falls
// R07: deselect never aborts running internal cycle
// R08: write-protect pin and bits block writes
// R09: quad mode turns write-protect into line 2
// R10: standard/dual use lines 0-1, quad 0-3
// R11: pin functions only outside four-line operation
// R12: quad-command instruction takes two clocks
// R13: continuous read skips instruction phase
// R14: read wrap in 8/16/32/64 byte window
// R15: double rate reads on both clock edges
// R16: program stays within one 256-byte page
// R17: erase in 4K sectors, 32K/64K blocks
// R18: unique identifier readable by host
// R19: three security areas with lock bits
// R20: pause pin low freezes and tristates
// R21: clear pin low 1us aborts everything
// R22: drive lines only in output phases
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_pin_if
  import sfp_pkg::*;
#(
  parameter int HWCLR_CYCLES = `SFP_HWCLR_CYCLES
)(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // flash pins
  input  wire logic        sclk,
  input  wire logic        csB,
  input  wire logic [3:0]  lineIn,
  output logic      [3:0]  lineOut,
  output logic      [3:0]  lineOe,
  // configuration
  input  wire logic        quadEnable,
  input  wire logic        quadCmdMode,
  input  wire logic        pin3FunctionSelect,
  input  wire sfp_prot_t   protCfg,
  input  wire logic [2:0]  lockBits,
  input  wire logic        wrapEnable,
  input  wire logic [1:0]  wrapSel,
  // core side
  output logic             cmdValid,
  output logic      [7:0]  cmdOp,
  output logic             rdReq,
  output sfp_xfer_t        rdInfo,
  input  wire logic [7:0]  rdData,
  output logic             wrValid,
  output sfp_xfer_t        wrInfo,
  output logic             eraseReq,
  output sfp_erase_t       eraseKind,
  output sfp_xfer_t        eraseInfo,
  output logic             abortReq,
  output logic             selected
);
  if (HWCLR_CYCLES < 1 || HWCLR_CYCLES > 255) begin : g_bad_clr
    $error("HWCLR_CYCLES out of range");
  end

  function automatic logic [5:0] laneBits(input sfp_lanes_t ln);
    case (ln)
      LN_4:    laneBits = 6'd4;
      LN_2:    laneBits = 6'd2;
      default: laneBits = 6'd1;
    endcase
  endfunction : laneBits
  function automatic logic [31:0] shiftIn(input logic [31:0] s, input logic [3:0] d, input sfp_lanes_t ln);
    case (ln)
      LN_4:    shiftIn = {s[27:0], d};
      LN_2:    shiftIn = {s[29:0], d[1:0]};
      default: shiftIn = {s[30:0], d[0]};
    endcase
  endfunction : shiftIn

  function automatic logic [23:0] nextAddr(input logic [23:0] a, input logic [5:0] winBits);
    logic [23:0] mask;
    mask = (24'h00_0001 << winBits) - 24'h00_0001;
    nextAddr = (a & ~mask) | ((a + 24'h00_0001) & mask);
  endfunction : nextAddr

  function automatic sfp_state_t phaseAfter(input sfp_cmd_t i, input logic modeDone, input logic dummyDone);
    if (i.hasMode && !modeDone) phaseAfter = ST_MODE;
    else if (i.dummy != 6'd0 && !dummyDone) phaseAfter = ST_DUMMY;
    else if (i.dir == DIR_OUT) phaseAfter = ST_DOUT;
    else if (i.dir == DIR_IN) phaseAfter = ST_DIN;
    else phaseAfter = ST_SKIP;
  endfunction : phaseAfter

  function automatic sfp_cmd_t decode(input logic [7:0] op, input logic qe, input logic quad_command_mode);
    sfp_cmd_t c;
    c = '{hasAddr: 1'b0, addrLanes: LN_1, hasMode: 1'b0, dummy: 6'd0, dataLanes: LN_1,
          dir: DIR_NONE, dtr: 1'b0, space: SP_ARRAY, erase: ER_NONE};
    case (op)
      `SFP_OP_READ:      begin c.hasAddr = 1'b1; c.dir = DIR_OUT; end
      `SFP_OP_FAST:      begin c.hasAddr = 1'b1; c.dir = DIR_OUT; c.dummy = `SFP_DUMMY_FAST; end
      `SFP_OP_FAST_DTR:  begin c.hasAddr = 1'b1; c.dir = DIR_OUT; c.dummy = `SFP_DUMMY_DTR; c.dtr = 1'b1; end
      `SFP_OP_DUAL_OUT:  begin c.hasAddr = 1'b1; c.dir = DIR_OUT; c.dummy = `SFP_DUMMY_FAST; c.dataLanes = LN_2; end
      `SFP_OP_DUAL_IO:   begin c.hasAddr = 1'b1; c.dir = DIR_OUT; c.addrLanes = LN_2; c.dataLanes = LN_2;
                               c.hasMode = 1'b1; end
      `SFP_OP_QUAD_OUT:  begin c.hasAddr = qe; c.dir = qe ? DIR_OUT : DIR_NONE; c.dummy = `SFP_DUMMY_FAST;
                               c.dataLanes = LN_4; end // R10
      `SFP_OP_QUAD_IO:   begin c.hasAddr = qe; c.dir = qe ? DIR_OUT : DIR_NONE; c.addrLanes = LN_4;
                               c.dataLanes = LN_4; c.hasMode = qe; c.dummy = `SFP_DUMMY_QIO; end
      `SFP_OP_QIO_DTR:   begin c.hasAddr = qe; c.dir = qe ? DIR_OUT : DIR_NONE; c.addrLanes = LN_4;
                               c.dataLanes = LN_4; c.hasMode = qe; c.dummy = `SFP_DUMMY_DTR; c.dtr = 1'b1; end // R15
      `SFP_OP_PROG:      begin c.hasAddr = 1'b1; c.dir = DIR_IN; end
      `SFP_OP_QPROG:     begin c.hasAddr = qe; c.dir = qe ? DIR_IN : DIR_NONE; c.dataLanes = LN_4; end
      `SFP_OP_ERASE4K:   begin c.hasAddr = 1'b1; c.erase = ER_4K; end // R17
      `SFP_OP_ERASE32K:  begin c.hasAddr = 1'b1; c.erase = ER_32K; end // R17
      `SFP_OP_ERASE64K:  begin c.hasAddr = 1'b1; c.erase = ER_64K; end // R17
      `SFP_OP_RDSTAT:    begin c.dir = DIR_OUT; c.space = SP_STATUS; end
      `SFP_OP_WRSTAT:    begin c.dir = DIR_IN; c.space = SP_STATUS; end
      `SFP_OP_UID:       begin c.dir = DIR_OUT; c.space = SP_UID; c.dummy = `SFP_DUMMY_UID; end // R18
      `SFP_OP_SECRD:     begin c.hasAddr = 1'b1; c.dir = DIR_OUT; c.space = SP_SECURE;
                               c.dummy = `SFP_DUMMY_FAST; end // R19
      `SFP_OP_SECPROG:   begin c.hasAddr = 1'b1; c.dir = DIR_IN; c.space = SP_SECURE; end // R19
      `SFP_OP_SECERASE:  begin c.hasAddr = 1'b1; c.space = SP_SECURE; c.erase = ER_4K; end // R19
      default:           c.dir = DIR_NONE;
    endcase
    if (quad_command_mode) begin
      c.addrLanes = LN_4; // R10
      c.dataLanes = LN_4;
    end
    decode = c;
  endfunction : decode

  // pin synchronisers: first stage feeds only the second
  logic [5:0]  syncA;
  logic [5:0]  syncB;
  logic        prevSclk;
  logic        prevCs;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA    <= 6'h00;
      syncB    <= 6'h00;
      prevSclk <= 1'b0;
      prevCs   <= 1'b0;
    end else if (ce) begin
      syncA    <= {sclk, csB, lineIn};
      syncB    <= syncA;
      prevSclk <= syncB[5];
      prevCs   <= syncB[4];
    end
  end

  logic        sclkS;
  logic        csS;
  logic [3:0]  dinS;
  logic        quadOn;
  logic        pinFuncOn;
  logic        paused;
  logic        clearing;
  logic        go;
  logic        rise;
  logic        fall;
  logic        csFall;
  logic        csRise;
  assign sclkS     = syncB[5];
  assign csS       = syncB[4];
  assign dinS      = syncB[3:0];
  assign quadOn    = quadEnable | quadCmdMode;
  assign pinFuncOn = ~quadOn; // R11
  assign paused    = pinFuncOn & ~pin3FunctionSelect & ~csS & ~dinS[3]; // R20
  assign go        = ~csS & ~paused & ~clearing;
  assign rise      = go & sclkS & ~prevSclk; // R01 R03
  assign fall      = go & ~sclkS & prevSclk; // R02
  assign csFall    = prevCs & ~csS;
  assign csRise    = ~prevCs & csS;

  // hardware clear: pin must stay low for the full count
  logic [7:0]  clrCnt;
  assign clearing = (clrCnt == 8'(HWCLR_CYCLES));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clrCnt   <= 8'h00;
      abortReq <= 1'b0;
    end else if (ce) begin
      abortReq <= 1'b0;
      if (!(pinFuncOn & pin3FunctionSelect & ~dinS[3])) begin
        clrCnt <= 8'h00;
      end else if (!clearing) begin
        clrCnt   <= clrCnt + 8'h01;
        abortReq <= (clrCnt == 8'(HWCLR_CYCLES - 1)); // R21
      end
    end
  end

  // frame sequencer
  sfp_state_t  state;
  sfp_state_t  stateQ;
  sfp_cmd_t    info;
  sfp_cmd_t    newInfo;
  logic [5:0]  cnt;
  logic [31:0] sh;
  logic [23:0] addr;
  logic        okWrite;
  logic        contRead;
  logic [7:0]  lastOp;
  sfp_lanes_t  inLanes;
  logic        capEdge;
  logic [31:0] next_sh;
  logic [5:0]  next_cnt;
  logic        arrayProt;
  logic        statusLock;
  logic [1:0]  area;

  always_comb begin
    case (state)
      ST_CMD:  inLanes = quadCmdMode ? LN_4 : LN_1; // R12
      ST_ADDR: inLanes = info.addrLanes;
      ST_MODE: inLanes = info.addrLanes;
      default: inLanes = info.dataLanes;
    endcase
  end
  assign capEdge  = rise | (fall & info.dtr & (state == ST_ADDR || state == ST_MODE)); // R15
  assign next_sh  = shiftIn(sh, dinS, inLanes);
  assign next_cnt = cnt + laneBits(inLanes);
  assign area     = next_sh[`SFP_SEC_AREA_HI:`SFP_SEC_AREA_LO];
  assign newInfo  = decode(next_sh[7:0], quadEnable, quadCmdMode);

  sfp_protect u_protect (
    .addr       (next_sh[23:0]),
    .cfg        (protCfg),
    .wpLevel    (dinS[2]),
    .quadOn     (quadOn),
    .arrayProt  (arrayProt),
    .statusLock (statusLock)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      stateQ   <= ST_IDLE;
      info     <= '0;
      cnt      <= 6'd0;
      sh       <= 32'h0000_0000;
      addr     <= 24'h00_0000;
      okWrite  <= 1'b0;
      contRead <= 1'b0;
      lastOp   <= 8'h00;
      cmdValid <= 1'b0;
      cmdOp    <= 8'h00;
      wrValid  <= 1'b0;
      wrInfo   <= '0;
      eraseReq <= 1'b0;
      eraseKind <= ER_NONE;
      eraseInfo <= '0;
      selected <= 1'b0;
    end else if (ce) begin
      stateQ   <= state;
      cmdValid <= 1'b0;
      wrValid  <= 1'b0;
      eraseReq <= 1'b0;
      selected <= ~csS & (state != ST_IDLE); // R05
      if (clearing) begin
        state    <= ST_IDLE;
        contRead <= 1'b0; // R21
      end else if (csRise) begin
        // the core finishes its cycle on its own; deselect only ends the frame
        if (state == ST_SKIP && info.erase != ER_NONE && okWrite) begin // R07
          eraseReq  <= 1'b1; // R17
          eraseKind <= info.erase;
          eraseInfo <= '{addr: addr, data: 8'h00, space: info.space};
        end
        state <= ST_IDLE; // R04
      end else if (csFall) begin
        // only a real high-to-low edge opens a frame
        cnt <= 6'd0; // R06
        sh  <= 32'h0000_0000;
        if (contRead) begin
          state <= ST_ADDR; // R13
          info  <= decode(lastOp, quadEnable, quadCmdMode);
        end else begin
          state <= ST_CMD;
        end
      end else if (capEdge) begin
        sh  <= next_sh;
        cnt <= next_cnt;
        case (state)
          ST_CMD: if (next_cnt == `SFP_CMD_BITS) begin
            cmdValid <= 1'b1;
            cmdOp    <= next_sh[7:0];
            lastOp   <= next_sh[7:0];
            info     <= newInfo;
            okWrite  <= ~statusLock;
            cnt      <= 6'd0;
            state    <= newInfo.hasAddr ? ST_ADDR : phaseAfter(newInfo, 1'b0, 1'b0);
          end
          ST_ADDR: if (next_cnt == `SFP_ADDR_BITS) begin
            addr    <= next_sh[23:0];
            okWrite <= (info.space == SP_SECURE) ? (area != 2'b00 && !lockBits[area - 2'd1]) : ~arrayProt;
            cnt     <= 6'd0;
            state   <= phaseAfter(info, 1'b0, 1'b0);
          end
          ST_MODE: if (next_cnt == `SFP_MODE_BITS) begin
            contRead <= (next_sh[5:4] == `SFP_CONT_MODE); // R13
            cnt      <= 6'd0;
            state    <= phaseAfter(info, 1'b1, 1'b0);
          end
          ST_DUMMY: begin
            cnt <= cnt + 6'd1;
            if (cnt + 6'd1 == info.dummy) begin
              cnt   <= 6'd0;
              state <= phaseAfter(info, 1'b1, 1'b1);
            end
          end
          ST_DIN: if (next_cnt == 6'(`SFP_BYTE_BITS)) begin
            cnt     <= 6'd0;
            wrValid <= okWrite; // R08
            wrInfo  <= '{addr: addr, data: next_sh[7:0], space: info.space};
            addr    <= nextAddr(addr, `SFP_PAGE_BITS); // R16
          end
          default: cnt <= 6'd0;
        endcase
      end
    end
  end

  // output path
  logic        launch;
  logic [3:0]  outLeft;
  logic [7:0]  outSh;
  logic [7:0]  byteNow;
  logic [3:0]  laneMask;
  logic [5:0]  winBits;
  assign launch  = (state == ST_DOUT) & (fall | (rise & info.dtr)); // R02 R15
  assign byteNow = (outLeft == 4'd0) ? rdData : outSh;
  assign winBits = (wrapEnable && info.space == SP_ARRAY) ? `SFP_WRAP_BASE + {4'd0, wrapSel} : `SFP_NO_WRAP;
  always_comb begin
    case (info.dataLanes)
      LN_4:    laneMask = 4'hF; // R09 R10
      LN_2:    laneMask = 4'h3; // R03
      default: laneMask = 4'h2;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lineOut <= 4'h0;
      lineOe  <= 4'h0;
      outLeft <= 4'd0;
      outSh   <= 8'h00;
      rdReq   <= 1'b0;
      rdInfo  <= '0;
    end else if (ce) begin
      rdReq <= 1'b0;
      if (state == ST_DOUT && stateQ != ST_DOUT) begin
        rdReq   <= 1'b1; // R05
        rdInfo  <= '{addr: addr, data: 8'h00, space: info.space};
        outLeft <= 4'd0;
      end else if (launch) begin
        case (info.dataLanes)
          LN_4:    lineOut <= byteNow[7:4];
          LN_2:    lineOut <= {2'b00, byteNow[7:6]};
          default: lineOut <= {2'b00, byteNow[7], 1'b0};
        endcase
        outSh   <= byteNow << laneBits(info.dataLanes);
        outLeft <= ((outLeft == 4'd0) ? `SFP_BYTE_BITS : outLeft) - 4'(laneBits(info.dataLanes));
        if (outLeft == 4'd0) begin
          rdReq       <= 1'b1;
          rdInfo.addr <= nextAddr(rdInfo.addr, winBits); // R14
        end
      end
      // drivers only in output phase of a live, unpaused frame
      if (state == ST_DOUT && go && (launch || lineOe != 4'h0)) begin // R22
        lineOe <= laneMask;
      end else begin
        lineOe <= 4'h0; // R04 R20
      end
    end
  end
endmodule : sfp_pin_if

// ---- verification/sfp_host_model.sv ----
// Purpose: host controller model driving clock, select and data lines
// Assumes: mode 0 framing, half period of four system clocks
// Notes: clock rests low between frames; wp and hold levels come from the bench
`timescale 1ns/1ps
module sfp_host_model (
  // pacing and pin levels
  input  wire logic       clk,
  input  wire logic       pinWp,
  input  wire logic       pinHold,
  input  wire logic [3:0] lineIn,
  // host pins
  output logic            sclk,
  output logic            csB,
  output logic      [3:0] hostOut,
  output logic      [3:0] hostOe
);
  logic       quad = 1'b0;
  logic [3:0] dv   = 4'h0;
  logic [3:0] dOe  = 4'h0;
  initial begin
    sclk = 1'b0;
    csB  = 1'b0; // no high-to-low edge seen yet
  end
  // wp and hold keep their pin role unless four lanes carry data
  assign hostOut = quad ? dv : {pinHold, pinWp, dv[1:0]};
  assign hostOe  = quad ? dOe : {2'b11, dOe[1:0]};

  task automatic half();
    repeat (4) @(posedge clk);
  endtask : half

  task automatic select();
    @(posedge clk);
    csB <= 1'b0;
    half();
  endtask : select

  task automatic deselect();
    half();
    csB  <= 1'b1;
    quad <= 1'b0;
    dOe  <= 4'h0;
    repeat (40) @(posedge clk);
  endtask : deselect

  // drive in the low phase, sample just after the rise
  task automatic shift(input int lanes, input int nbits, input logic [31:0] dout, input bit rd,
                       output logic [31:0] din);
    logic [3:0]  m;
    logic [31:0] v;
    m   = (lanes == 4) ? 4'hf : (lanes == 2) ? 4'h3 : 4'h1;
    din = '0;
    for (int i = nbits; i > 0; i -= lanes) begin
      v = dout >> (i - lanes);
      quad <= (lanes == 4);
      dv   <= v[3:0] & m;
      dOe  <= rd ? 4'h0 : m;
      half();
      sclk <= 1'b1;
      #1;
      din = (din << lanes) | ((lanes == 1) ? 32'(lineIn[1]) : 32'(lineIn & m));
      half();
      sclk <= 1'b0;
    end
  endtask : shift
endmodule : sfp_host_model

// ---- verification/sfp_pin_if_sva.sv ----
// Purpose: port-level checks of the flash pin front end
// Assumes: ce held high
// Notes: the deselect checks allow up to six clocks of sync latency
`timescale 1ns/1ps
module sfp_pin_if_sva
  import sfp_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // pins and configuration
  input wire logic       csB,
  input wire logic [3:0] lineIn,
  input wire logic [3:0] lineOe,
  input wire logic       quadEnable,
  input wire logic       pin3FunctionSelect,
  // core side
  input wire logic       selected,
  input wire logic       cmdValid,
  input wire logic       rdReq,
  input wire logic       wrValid,
  input wire logic       eraseReq,
  input wire sfp_erase_t eraseKind,
  input wire logic       abortReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // long enough to pass both sync stages and the output flop
  sequence deselLong;
    csB [*6];
  endsequence
  a_desel_tristate: assert property (deselLong |-> lineOe == 4'h0)
    else $error("lines driven while deselected");
  a_desel_unselect: assert property (deselLong |-> !selected)
    else $error("frame open while deselected");
  a_oe_lane_set: assert property (lineOe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("output lanes outside a legal set");
  a_upper_needs_quad: assert property (|lineOe[3:2] |-> quadEnable)
    else $error("upper lanes driven without quad");
  a_oe_in_frame: assert property (|lineOe |-> selected || $past(selected))
    else $error("lines driven outside a frame");
  a_cmd_in_frame: assert property (cmdValid |-> selected ##1 !cmdValid)
    else $error("command outside frame or stretched");
  a_read_pulse: assert property (rdReq |-> selected ##1 !rdReq)
    else $error("read request outside frame or stretched");
  a_write_in_frame: assert property (wrValid |-> selected)
    else $error("write outside frame");
  a_erase_after_desel: assert property (eraseReq |-> csB && eraseKind != ER_NONE)
    else $error("erase issued inside frame or without kind");
  a_clear_cause: assert property (abortReq |-> pin3FunctionSelect && !quadEnable && !$past(lineIn[3], 3))
    else $error("abort without clear pin function");
  a_clear_once: assert property (abortReq |=> !abortReq [*3])
    else $error("abort repeated while pin held");
endmodule : sfp_pin_if_sva

bind sfp_pin_if sfp_pin_if_sva i_sfp_pin_if_sva (.clk(clk), .rst_b(rst_b), .csB(csB), .lineIn(lineIn),
  .lineOe(lineOe), .quadEnable(quadEnable), .pin3FunctionSelect(pin3FunctionSelect), .selected(selected),
  .cmdValid(cmdValid), .rdReq(rdReq), .wrValid(wrValid), .eraseReq(eraseReq), .eraseKind(eraseKind),
  .abortReq(abortReq));

// ---- verification/tb_top.sv ----
// Purpose: frame-level tests of the flash pin front end
// Assumes: bench core answers reads at once
// Notes: wrap and clock enable left static
`timescale 1ns/1ps
module tb_top import sfp_pkg::*; ;
  localparam int HWCLR = 4;
  localparam int LIMIT = 30000;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        quadEnable = 1'b0;
  logic        quadCmdMode = 1'b0;
  logic        pin3FunctionSelect = 1'b0;
  sfp_prot_t   protCfg = '0;
  logic [2:0]  lockBits = 3'h0;
  logic        pinWp = 1'b1;
  logic        pinHold = 1'b1;
  logic [3:0]  flt = 4'h5;
  logic        sclk, csB, cmdValid, rdReq, wrValid, eraseReq, abortReq, selected;
  logic [3:0]  lineIn, lineOut, lineOe, hostOut, hostOe;
  logic [7:0]  rdData, cmdOp;
  sfp_xfer_t   rdInfo, wrInfo, eraseInfo;
  sfp_erase_t  eraseKind;
  logic [31:0] got;
  int          n_errors = 0, total_checks = 0, nCmd = 0, nWr = 0, nErase = 0, nAbort = 0, cyc = 0, n0;
  logic [7:0]  rOp [3] = '{8'h03, 8'h3B, 8'h6B};
  logic [7:0]  wOp [6] = '{8'h02, 8'h02, 8'h42, 8'h42, 8'h01, 8'h01};
  logic [23:0] wAd [6] = '{24'h00_0100, 24'hff_ff00, 24'h00_1000, 24'h00_2000, 24'h00_0000, 24'h00_0000};
  logic [7:0]  wPr [6] = '{8'h00, 8'he0, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [2:0]  wFl [6] = '{3'b101, 3'b100, 3'b100, 3'b101, 3'b000, 3'b011}; // wp, quad, expected write
  logic [7:0]  eOp [3] = '{8'h20, 8'h52, 8'hD8};
  sfp_erase_t  eKd [3] = '{ER_4K, ER_32K, ER_64K};

  always #10 clk = ~clk;
  // undriven lines wander every cycle so a stale value never looks valid
  assign lineIn = (lineOe & lineOut) | (~lineOe & hostOe & hostOut) | (~lineOe & ~hostOe & flt);
  assign rdData = rdInfo.addr[7:0] ^ 8'h5a;

  sfp_pin_if #(.HWCLR_CYCLES(HWCLR)) i_sfp_pin_if (.clk(clk), .rst_b(rst_b), .ce(1'b1), .sclk(sclk), .csB(csB),
    .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe), .quadEnable(quadEnable), .quadCmdMode(quadCmdMode),
    .pin3FunctionSelect(pin3FunctionSelect), .protCfg(protCfg), .lockBits(lockBits), .wrapEnable(1'b0),
    .wrapSel(2'b00), .cmdValid(cmdValid), .cmdOp(cmdOp), .rdReq(rdReq), .rdInfo(rdInfo), .rdData(rdData),
    .wrValid(wrValid), .wrInfo(wrInfo), .eraseReq(eraseReq), .eraseKind(eraseKind), .eraseInfo(eraseInfo),
    .abortReq(abortReq), .selected(selected));
  sfp_host_model i_host (.clk(clk), .pinWp(pinWp), .pinHold(pinHold), .lineIn(lineIn), .sclk(sclk), .csB(csB),
    .hostOut(hostOut), .hostOe(hostOe));

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic frame(input int opL, input logic [7:0] op, input int aBits, input logic [23:0] addr,
                       input int dL, input int dum, input int nData, input bit rd, input logic [7:0] data);
    i_host.select();
    i_host.shift(opL, 8, 32'(op), 1'b0, got);
    if (aBits > 0) i_host.shift(1, aBits, 32'(addr), 1'b0, got);
    if (dum > 0) i_host.shift(dL, dum * dL, 32'h0, 1'b1, got);
    if (nData > 0) i_host.shift(dL, nData, 32'(data), rd, got);
    i_host.deselect();
    check(32'(lineOe), 32'h0);
  endtask : frame

  always @(posedge clk) begin
    flt <= ~flt;
    cyc++;
    if (cmdValid === 1'b1) nCmd++;
    if (wrValid === 1'b1) nWr++;
    if (eraseReq === 1'b1) nErase++;
    if (abortReq === 1'b1) nAbort++;
    if (cyc == LIMIT) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(selected), 32'h0);
    frame(1, 8'h03, 24, 24'h00_0010, 1, 0, 8, 1'b1, 8'h00);
    check(32'(nCmd), 32'h0);
    for (int k = 0; k < 3; k++) begin
      quadEnable <= (k == 2);
      frame(1, rOp[k], 24, 24'h00_0040 + 24'(k), 1 << k, (k > 0) ? 8 : 0, 8, 1'b1, 8'h00);
      check(got, 32'(8'h5a ^ (8'h40 + 8'(k))));
      check(32'(cmdOp), 32'(rOp[k]));
    end
    for (int k = 0; k < 6; k++) begin
      protCfg <= wPr[k];
      lockBits <= (k == 2) ? 3'h7 : 3'h0;
      {pinWp, quadEnable} <= wFl[k][2:1];
      n0 = nWr;
      frame(1, wOp[k], (wOp[k] == 8'h01) ? 0 : 24, wAd[k], 1, 0, 8, 1'b0, 8'hc3);
      check(32'(nWr - n0), 32'(wFl[k][0]));
      if (wFl[k][0] && wOp[k] != 8'h01) check({wrInfo.addr, wrInfo.data}, {wAd[k], 8'hc3});
    end
    protCfg <= '0;
    quadEnable <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      n0 = nErase;
      frame(1, eOp[k], 24, 24'h01_0000, 1, 0, 0, 1'b0, 8'h00);
      check(32'(nErase - n0), 32'h1);
      check(32'(eraseKind), 32'(eKd[k]));
      check(32'(eraseInfo.addr), 32'h01_0000);
    end
    quadEnable <= 1'b1;
    quadCmdMode <= 1'b1;
    n0 = nCmd;
    frame(4, 8'h05, 0, 24'h0, 4, 0, 0, 1'b0, 8'h00);
    check(32'(nCmd - n0), 32'h1);
    check(32'(cmdOp), 32'h05);
    quadEnable <= 1'b0;
    quadCmdMode <= 1'b0;
    i_host.select();
    i_host.shift(1, 8, 32'h03, 1'b0, got);
    i_host.shift(1, 24, 32'h100, 1'b0, got);
    i_host.shift(1, 3, 32'h0, 1'b1, got);
    check(32'(lineOe), 32'h2);
    pinHold <= 1'b0;
    repeat (8) @(posedge clk);
    check(32'(lineOe), 32'h0);
    pinHold <= 1'b1;
    i_host.shift(1, 5, 32'h0, 1'b1, got);
    i_host.deselect();
    pin3FunctionSelect <= 1'b1;
    for (int q = 0; q < 2; q++) begin
      quadEnable <= q[0];
      n0 = nAbort;
      @(posedge clk);
      pinHold <= 1'b0;
      repeat (HWCLR + 8) @(posedge clk);
      pinHold <= 1'b1;
      repeat (8) @(posedge clk);
      check(32'(nAbort - n0), 32'(q == 0));
    end
    final_report();
  end
endmodule : tb_top
